// [rtl/sbs_counter.sv]
// sbs_counter.sv: stored-triplet counter with saturation and overflow event
// assumes: push and pop are one-cycle strobes on clk_i; clear wins over everything
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_counter #(
   parameter int DEPTH = 32
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             clear_i,
   input  wire logic             push_i,
   input  wire logic             pop_i,
   output logic [`SBS_CNT_W-1:0] cnt_o,
   output logic                  overflow_o
);
   import sbs_pkg::*;

   typedef struct packed {
      logic [`SBS_CNT_W-1:0] cnt;
      logic                  ovf;
   } sbs_cnt_state_t;

   sbs_cnt_state_t s_q, s_d;
   logic           full;

   assign full       = (s_q.cnt == `SBS_CNT_W'(DEPTH));
   assign cnt_o      = s_q.cnt;
   assign overflow_o = s_q.ovf;

   always_comb begin
      s_d     = s_q;
      s_d.ovf = 1'b0;
      if (clear_i) begin
         s_d.cnt = '0;
      end else if (push_i && !pop_i) begin
         if (full) begin
            s_d.ovf = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + `SBS_CNT_W'(1);
         end
      end else if (pop_i && !push_i && s_q.cnt != '0) begin
         s_d.cnt = s_q.cnt - `SBS_CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : sbs_counter

// [rtl/sbs_pkg.sv]
// sbs_pkg.sv: types shared by the sample buffer status block
// assumes: the _regs header supplies the numbers
`include "sbs_regs.svh"
package sbs_pkg;

   typedef struct packed {
      logic                  wmrk;
      logic                  ovf;
      logic [`SBS_CNT_W-1:0] cnt;
   } sbs_status_t;

   typedef struct packed {
      logic       push;
      logic       pop;
   } sbs_events_t;

   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic       we;
      logic [3:0] sel;
      logic       req;
   } sbs_wb_req_t;

endpackage : sbs_pkg

// [rtl/sbs_regs.svh]
// sbs_regs.svh: register offsets, field positions, reset values and sizes of the sample buffer status block
// assumes: included once per compilation unit by its bare name
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

`define SBS_ADDR_STATUS     8'h0b
`define SBS_ADDR_CONFIG1    8'h10
`define SBS_ADDR_CONFIG2    8'h14
`define SBS_ADDR_IRQ_STATUS 8'h18
`define SBS_ADDR_IRQ_MASK   8'h1c

`define SBS_STATUS_RESET    8'h00
`define SBS_WMRK_BIT        7
`define SBS_OVF_BIT         6
`define SBS_MODE_OFF        2'h0
`define SBS_FLUSH_BIT       6
`define SBS_DEPTH           6'h20
`define SBS_CNT_W           6
`define SBS_TRIPLET_BYTES   4'h6

`define SBS_IRQ_WMRK        0
`define SBS_IRQ_OVF         1
`define SBS_IRQ_W           2

`endif

// [rtl/sbs_top.sv]
// sbs_top.sv: sample buffer status byte, buffer configuration and interrupt logic, Wishbone slave
// assumes: storage lives outside; push_i marks a triplet offered, pop_rd_i a host read of one buffered byte
//
// Contract
// - mode 00b makes status read 00h
// - bit7 watermark, bit6 overflow, 5:0 count
// - watermark set when count reaches level
// - watermark clears when reads drop below level
// - flush empties buffer, clears watermark
// - mode 00b disables, empties, clears watermark
// - overflow set only after 33rd triplet
// - draining burst leaves buffer empty, flags clear
// - count saturates at 32, overflow raised
// - overflow cleared by read, flush, disable
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_top #(
   parameter int DEPTH = 32
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        push_i,
   input  wire logic        pop_rd_i,
   output logic             flush_o,
   output logic [1:0]       buffer_mode_o,
   output logic [`SBS_CNT_W-1:0] stored_triplet_count_o,
   output logic             irq_o
);
   import sbs_pkg::*;

   typedef struct packed {
      logic [7:0]            cfg1;
      logic [7:0]            cfg2;
      logic                  wmrk;
      logic                  ovf;
      logic [3:0]            byte_cnt;
      logic [`SBS_IRQ_W-1:0] irq_st;
      logic [`SBS_IRQ_W-1:0] irq_mask;
      logic                  ack;
      logic [31:0]           rdata;
      logic                  flush;
      logic                  irq;
   } sbs_state_t;

   sbs_state_t            s_q, s_d;
   sbs_status_t           status;
   logic [`SBS_CNT_W-1:0] cnt;
   logic                  ovf_evt;
   logic                  req;
   logic                  wr;
   logic                  rd;
   logic                  clear_cnt;
   logic                  enabled;
   logic                  pop_strobe;
   logic                  new_flush;
   logic                  new_off;
   logic [`SBS_CNT_W-1:0] level;

   // register hit test used by both the read and the write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   assign req       = cyc_i && stb_i && !s_q.ack;
   assign wr        = req && we_i && sel_i[0];
   assign rd        = req && !we_i;
   assign enabled   = (s_q.cfg1[1:0] != `SBS_MODE_OFF);
   assign level     = s_q.cfg2[`SBS_CNT_W-1:0];
   assign new_flush = wr && hit(adr_i, `SBS_ADDR_CONFIG2) && dat_i[`SBS_FLUSH_BIT];
   assign new_off   = wr && hit(adr_i, `SBS_ADDR_CONFIG1) && dat_i[1:0] == `SBS_MODE_OFF;
   assign clear_cnt = new_flush || new_off || !enabled;

   // a triplet is consumed once all six of its bytes have been read
   assign pop_strobe = pop_rd_i && enabled && (s_q.byte_cnt == `SBS_TRIPLET_BYTES - 4'h1);

   sbs_counter #(
      .DEPTH(DEPTH)
   ) u_counter (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .clear_i   (clear_cnt),
      .push_i    (push_i && enabled),
      .pop_i     (pop_strobe),
      .cnt_o     (cnt),
      .overflow_o(ovf_evt)
   );

   always_comb begin
      status.wmrk = s_q.wmrk;
      status.ovf  = s_q.ovf;
      status.cnt  = cnt;
      if (!enabled) begin
         status = `SBS_STATUS_RESET;
      end
   end

   always_comb begin
      s_d       = s_q;
      s_d.ack   = req;
      s_d.flush = 1'b0;
      s_d.irq   = |(s_q.irq_st & s_q.irq_mask);

      // watermark follows the count; a zero level only flags with data present
      s_d.wmrk = enabled && (cnt >= level) && (cnt != '0);
      if (ovf_evt) begin
         s_d.ovf = 1'b1;
      end else if (pop_strobe || clear_cnt) begin
         s_d.ovf = 1'b0;
      end
      if (clear_cnt) begin
         s_d.wmrk = 1'b0;
      end

      if (clear_cnt) begin
         s_d.byte_cnt = '0;
      end else if (pop_rd_i && enabled) begin
         s_d.byte_cnt = pop_strobe ? 4'h0 : s_q.byte_cnt + 4'h1;
      end

      // read clears the interrupt status, but a new event in the same cycle survives
      if (rd && hit(adr_i, `SBS_ADDR_IRQ_STATUS)) begin
         s_d.irq_st = '0;
      end
      if (s_d.wmrk && !s_q.wmrk) begin
         s_d.irq_st[`SBS_IRQ_WMRK] = 1'b1;
      end
      if (ovf_evt) begin
         s_d.irq_st[`SBS_IRQ_OVF] = 1'b1;
      end

      if (wr) begin
         if (hit(adr_i, `SBS_ADDR_CONFIG1)) begin
            s_d.cfg1 = dat_i[7:0];
         end else if (hit(adr_i, `SBS_ADDR_CONFIG2)) begin
            s_d.cfg2 = {dat_i[7], 1'b0, dat_i[5:0]}; // flush bit self-clears
            s_d.flush = dat_i[`SBS_FLUSH_BIT];
         end else if (hit(adr_i, `SBS_ADDR_IRQ_MASK)) begin
            s_d.irq_mask = dat_i[`SBS_IRQ_W-1:0];
         end
      end

      s_d.rdata = '0;
      if (rd) begin
         if (hit(adr_i, `SBS_ADDR_STATUS)) begin
            s_d.rdata = {24'h0, status};
         end else if (hit(adr_i, `SBS_ADDR_CONFIG1)) begin
            s_d.rdata = {24'h0, s_q.cfg1};
         end else if (hit(adr_i, `SBS_ADDR_CONFIG2)) begin
            s_d.rdata = {24'h0, s_q.cfg2};
         end else if (hit(adr_i, `SBS_ADDR_IRQ_STATUS)) begin
            s_d.rdata = {30'h0, s_q.irq_st};
         end else if (hit(adr_i, `SBS_ADDR_IRQ_MASK)) begin
            s_d.rdata = {30'h0, s_q.irq_mask};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o                  = s_q.rdata;
   assign ack_o                  = s_q.ack;
   assign flush_o                = s_q.flush;
   assign buffer_mode_o          = s_q.cfg1[1:0];
   assign stored_triplet_count_o = cnt;
   assign irq_o                  = s_q.irq;

endmodule : sbs_top

// [testbench/sbs_host.sv]
// sbs_host.sv: host model, Wishbone register cycles, triplet pushes and byte pops
// assumes: shares the block clock; each call starts just after a rising edge
`timescale 1ns/1ps
module sbs_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] rdat_i,
   output logic             cyc_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [31:0]      wdat_o,
   output logic             push_o,
   output logic             pop_o
);
   initial {cyc_o, we_o, adr_o, wdat_o, push_o, pop_o} = '0;
   // request stays put until ack is sampled; the idle cycle keeps cycles apart
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      {cyc_o, we_o, adr_o, wdat_o} <= {1'b1, w, a, 24'h0, d};
      // ack and data are looked at mid-cycle, where they stand settled; reading them at the
      // launching edge would race the block's own flops
      do @(negedge clk_i); while (ack_i !== 1'b1);
      q = rdat_i[7:0];
      @(posedge clk_i);
      {cyc_o, we_o} <= 2'b00;
      @(posedge clk_i);
   endtask : bus
   // p high: n triplets offered; p low: n buffered bytes read, six per triplet
   task automatic ev(input bit p, input int n);
      repeat (n) begin
         {push_o, pop_o} <= {p, !p};
         @(posedge clk_i);
         {push_o, pop_o} <= 2'b00;
         @(posedge clk_i);
      end
   endtask : ev
endmodule : sbs_host

// [testbench/sbs_top_monitor.sv]
// sbs_top_monitor.sv: port checks of the sample buffer status block
// assumes: bound into every sbs_top; one clock, sync reset
`timescale 1ns/1ps
module sbs_chk #(
   parameter int DEPTH = 32
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        push_i,
   input wire logic        pop_rd_i,
   input wire logic        flush_o,
   input wire logic [1:0]  buffer_mode_o,
   input wire logic [5:0]  stored_triplet_count_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic [5:0] c = stored_triplet_count_o;
   wire logic [5:0] f = 6'(DEPTH);
   wire logic       rd = ack_o && !we_i;
   // bus writes may reconfigure, so a lone push is only judged with the bus idle
   wire logic       up = push_i && !pop_rd_i && !flush_o && !cyc_i;
   property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_one; ack_o |=> !ack_o; endproperty
   a_one: assert property (p_one) else $error("ack held");
   property p_off; (buffer_mode_o == 2'h0)[*2] ##0 rd && adr_i == 8'h0b |-> dat_o == 32'h0; endproperty
   a_off: assert property (p_off) else $error("status not zero when off");
   property p_hi; rd |-> dat_o[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_max; c <= f; endproperty
   a_max: assert property (p_max) else $error("count above depth");
   property p_sat; up && c == f |=> c == f; endproperty
   a_sat: assert property (p_sat) else $error("count left full");
   property p_inc; up && buffer_mode_o != 2'h0 && c < f |=> c == $past(c) + 6'h1; endproperty
   a_inc: assert property (p_inc) else $error("push not counted");
   property p_clr; (buffer_mode_o == 2'h0)[*2] |-> c == 6'h0; endproperty
   a_clr: assert property (p_clr) else $error("count kept when off");
   property p_fl; flush_o |-> ##[0:2] c == 6'h0; endproperty
   a_fl: assert property (p_fl) else $error("flush kept count");
endmodule : sbs_chk
bind sbs_top sbs_chk #(.DEPTH(DEPTH)) u_chk (
   .clk_i                 (clk_i),
   .rst_i                 (rst_i),
   .cyc_i                 (cyc_i),
   .stb_i                 (stb_i),
   .we_i                  (we_i),
   .adr_i                 (adr_i),
   .dat_o                 (dat_o),
   .ack_o                 (ack_o),
   .push_i                (push_i),
   .pop_rd_i              (pop_rd_i),
   .flush_o               (flush_o),
   .buffer_mode_o         (buffer_mode_o),
   .stored_triplet_count_o(stored_triplet_count_o)
);

// [testbench/tb_sbs_top.sv]
// tb_sbs_top.sv: self-checking bench of the sample buffer status block
// assumes: sbs_host drives bus and strobes; sbs_chk is bound to the block
`timescale 1ns/1ps
module tb_sbs_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc, we, push, pop, ack, irq;
   logic [7:0]  adr, q;
   logic [31:0] wdat, rdat;
   int          n_errors = 0;
   int          checks = 0;
   int          cycles = 0;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
   sbs_host host (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .we_o(we), .adr_o(adr),
                  .wdat_o(wdat), .push_o(push), .pop_o(pop));
   sbs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hf),
                .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .push_i(push), .pop_rd_i(pop), .flush_o(),
                .buffer_mode_o(), .stored_triplet_count_o(), .irq_o(irq));
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host.bus(1'b0, a, 8'h00, q);
      `CHK("read data", e, q)
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.bus(1'b1, a, d, q);
   endtask : wr
   // irq lags its status by a cycle, so look two falling edges later
   task automatic irq_is(input logic e);
      repeat (2) @(negedge clk_i);
      `CHK("irq_o", e, irq)
      @(posedge clk_i);
   endtask : irq_is
   task automatic t_wmrk();
      rd(8'h0b, 8'h00);
      rd(8'h3f, 8'h00);
      host.ev(1'b1, 3);
      rd(8'h0b, 8'h00);
      wr(8'h10, 8'h01);
      wr(8'h14, 8'h04);
      host.ev(1'b1, 3);
      rd(8'h0b, 8'h03);
      host.ev(1'b1, 1);
      rd(8'h0b, 8'h84);
      irq_is(1'b0);
      wr(8'h1c, 8'h01);
      irq_is(1'b1);
      rd(8'h18, 8'h01);
      irq_is(1'b0);
      host.ev(1'b0, 6);
      rd(8'h0b, 8'h03);
      $display("watermark test done");
   endtask : t_wmrk
   task automatic t_ovf();
      host.ev(1'b1, 29);
      rd(8'h0b, 8'ha0);
      host.ev(1'b1, 1);
      rd(8'h0b, 8'he0);
      host.ev(1'b0, 6);
      rd(8'h0b, 8'h9f);
      $display("overflow test done");
   endtask : t_ovf
   task automatic t_clear();
      wr(8'h14, 8'h44);
      rd(8'h0b, 8'h00);
      host.ev(1'b1, 5);
      wr(8'h10, 8'h00);
      rd(8'h0b, 8'h00);
      wr(8'h10, 8'h03);
      rd(8'h0b, 8'h00);
      host.ev(1'b1, 4);
      rd(8'h0b, 8'h84);
      host.ev(1'b0, 24);
      rd(8'h0b, 8'h00);
      $display("clear test done");
   endtask : t_clear
   task automatic conclude();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   initial forever #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         n_errors++;
         conclude();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_wmrk();
      t_ovf();
      t_clear();
      conclude();
   end
endmodule : tb_sbs_top
